// >>> fdc_result_pkg.sv
/*
 * Package for the floppy result-status block: register map, register
 * field positions, status byte zero interrupt codes and the event carrier struct.
 * Assumes a 32-bit AXI4-Lite register bus on a single 100 MHz clock.
 */
package fdc_result_pkg;

	// register byte addresses, and PORT_INDEX, the word index of the port
	localparam logic [3:0] PORT_INDEX     = 4'h5;
	localparam logic [7:0] ADDR_PORT      = 8'h14;
	localparam logic [7:0] ADDR_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_STATE     = 8'h04;
	localparam logic [7:0] ADDR_CMD_LAST  = 8'h08;

	// control register fields
	localparam int CTRL_DRIVE_LO  = 0;
	localparam int CTRL_HEAD      = 2;
	localparam int CTRL_CMD_OK    = 3;

	// state register fields
	localparam int STATE_PTR_LO   = 0;
	localparam int STATE_ENABLED  = 2;
	localparam int STATE_BUSY     = 3;
	localparam int STATE_RESULT   = 4;

	// configure command opcode enables the port buffering
	localparam logic [7:0] CMD_CONFIGURE = 8'h13;

	// interrupt codes of status byte zero
	localparam logic [1:0] IC_NORMAL   = 2'h0;
	localparam logic [1:0] IC_ABNORMAL = 2'h1;
	localparam logic [1:0] IC_INVALID  = 2'h2;
	localparam logic [1:0] IC_RDY_CHG  = 2'h3;

	// step pulses allowed before missing track zero counts as a fault
	localparam logic [6:0] TRACK0_STEP_LIMIT = 7'h4d;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// execution events from the controller core, one-cycle pulses
	typedef struct packed {
		logic       done;
		logic       invalid;
		logic       seek_cmd;
		logic       seek_ok;
		logic       step;
		logic       past_last_sector;
		logic       id_crc_fault;
		logic       data_crc_fault;
		logic       host_late;
		logic       sector_missing;
		logic       write_cmd;
		logic       addr_mark_absent;
		logic       read_or_scan;
		logic       control_mark;
		logic       wrong_cylinder;
		logic       scan_cmd;
		logic       scan_equal;
		logic       scan_unmet;
		logic       bad_cylinder;
	} exec_event_s;

	// drive-side pin levels
	typedef struct packed {
		logic fault;
		logic track_zero;
		logic ready;
		logic write_protect;
	} drive_pins_s;

	typedef enum logic [1:0] {PTR_ZERO, PTR_ONE, PTR_TWO} result_ptr_e;

endpackage

// >>> floppy_result_status.sv
/*
 * Result-status stack behind the command/data port. Commands are written
 * to the port; after the core finishes, three status bytes are read back
 * from it one per access, zero first.
 * Assumes an AXI4-Lite master, execution event pulses from the controller
 * core on the same clock, and asynchronous drive pins.
 */
// Decided for this implementation: register access over AXI4-Lite.
module floppy_result_status
	import fdc_result_pkg::*;
(
	// clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        CE,
	// axi4-lite write address
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output      logic        S_AXI_AWREADY,
	// axi4-lite write data
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output      logic        S_AXI_WREADY,
	// axi4-lite write response
	output      logic [1:0]  S_AXI_BRESP,
	output      logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// axi4-lite read address
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output      logic        S_AXI_ARREADY,
	// axi4-lite read data
	output      logic [31:0] S_AXI_RDATA,
	output      logic [1:0]  S_AXI_RRESP,
	output      logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// controller core
	input  wire exec_event_s EXEC_EVENT,
	output      logic        CMD_STROBE,
	output      logic [7:0]  CMD_BYTE,
	// drive pins, asynchronous
	input  wire drive_pins_s DRIVE_PINS
);

	drive_pins_s pins_meta_q;
	drive_pins_s pins_q;
	logic        aw_held_q;
	logic [7:0]  aw_addr_q;
	logic        w_held_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [2:0]  control_q;
	logic        enabled_q;
	logic        busy_q;
	logic        result_q;
	result_ptr_e ptr_q;
	logic [7:0]  cmd_last_q;
	logic        cmd_strobe_q;
	logic [7:0]  cmd_byte_q;
	logic [7:0]  st0_q;
	logic [7:0]  st1_q;
	logic [7:0]  st2_q;
	logic [6:0]  step_cnt_q;
	logic        ready_start_q;
	logic        rdy_changed_q;

	logic        wr_fire;
	logic        rd_fire;
	logic        port_wr;
	logic        port_rd;
	logic [7:0]  port_byte;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        wr_ok;
	logic [1:0]  ic_d;
	logic [7:0]  st0_d;
	logic [7:0]  st1_d;
	logic [7:0]  st2_d;

	// drive pins pass two flops before use
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			pins_meta_q <= '0;
			pins_q      <= '0;
		end
		else if (CE)
		begin
			pins_meta_q <= DRIVE_PINS;
			pins_q      <= pins_meta_q;
		end
	end

	// write channels are taken in either order, held until both are in
	assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
	assign S_AXI_WREADY  = !w_held_q && !bvalid_q;
	assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= BYTE_ZERO;
			w_held_q  <= 1'b0;
			w_data_q  <= WORD_ZERO;
			w_strb_q  <= '0;
		end
		else if (CE)
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end
			else if (wr_fire)
				aw_held_q <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			else if (wr_fire)
				w_held_q <= 1'b0;
		end
	end

	assign wr_ok   = (aw_addr_q == ADDR_PORT) || (aw_addr_q == ADDR_CONTROL);
	// port writes only land when no command is busy and no result is pending; with buffering off, others only set cmd_last_q
	assign port_wr = wr_fire && (aw_addr_q == ADDR_PORT) && w_strb_q[0];

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= AXI_OKAY;
		end
		else if (CE)
		begin
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_BREADY)
				bvalid_q <= 1'b0;
		end
	end

	// control register: drive select and head, bits 2:0 only
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			control_q <= '0;
		else if (CE && wr_fire && aw_addr_q == ADDR_CONTROL && w_strb_q[0])
			control_q <= w_data_q[2:0];
	end

	// command path; configure enables buffering, others need it enabled
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			enabled_q    <= 1'b0;
			busy_q       <= 1'b0;
			cmd_last_q   <= BYTE_ZERO;
			cmd_strobe_q <= 1'b0;
			cmd_byte_q   <= BYTE_ZERO;
		end
		else if (CE)
		begin
			cmd_strobe_q <= 1'b0;
			// a port write in the cycle of an end starts no command, as busy_q is still set
			if (EXEC_EVENT.done || EXEC_EVENT.invalid)
				busy_q <= 1'b0;
			if (port_wr && !busy_q && !result_q)
			begin
				cmd_last_q <= w_data_q[7:0];
				if (w_data_q[7:0] == CMD_CONFIGURE)
					enabled_q <= 1'b1;
				else if (enabled_q)
				begin
					cmd_strobe_q <= 1'b1;
					cmd_byte_q   <= w_data_q[7:0];
					busy_q       <= 1'b1;
				end
			end
		end
	end

	assign CMD_STROBE = cmd_strobe_q;
	assign CMD_BYTE   = cmd_byte_q;

	// step pulses since command start, saturating
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			step_cnt_q    <= '0;
			ready_start_q <= 1'b0;
			rdy_changed_q <= 1'b0;
		end
		else if (CE)
		begin
			if (cmd_strobe_q)
			begin
				step_cnt_q    <= '0;
				ready_start_q <= pins_q.ready;
				rdy_changed_q <= 1'b0;
			end
			else
			begin
				if (EXEC_EVENT.step && step_cnt_q != TRACK0_STEP_LIMIT)
					step_cnt_q <= step_cnt_q + 7'h01;
				if (busy_q && pins_q.ready != ready_start_q)
					rdy_changed_q <= 1'b1;
			end
		end
	end

	// status byte assembly at command end
	always_comb
	begin
		if (EXEC_EVENT.invalid)
			ic_d = IC_INVALID;
		else if (rdy_changed_q)
			ic_d = IC_RDY_CHG;
		else if (st1_d != BYTE_ZERO || st2_d != BYTE_ZERO || pins_q.fault
			|| (EXEC_EVENT.seek_cmd && !EXEC_EVENT.seek_ok))
			ic_d = IC_ABNORMAL;
		else
			ic_d = IC_NORMAL;
		st0_d = {ic_d,
			EXEC_EVENT.seek_cmd && EXEC_EVENT.seek_ok,
			pins_q.fault || (step_cnt_q == TRACK0_STEP_LIMIT && !pins_q.track_zero),
			!pins_q.ready,
			control_q[CTRL_HEAD],
			control_q[CTRL_DRIVE_LO +: 2]};
		st1_d = {EXEC_EVENT.past_last_sector,
			1'b0,
			EXEC_EVENT.id_crc_fault || EXEC_EVENT.data_crc_fault,
			EXEC_EVENT.host_late,
			1'b0,
			EXEC_EVENT.sector_missing,
			EXEC_EVENT.write_cmd && pins_q.write_protect,
			EXEC_EVENT.addr_mark_absent};
		st2_d = {1'b0,
			EXEC_EVENT.read_or_scan && EXEC_EVENT.control_mark,
			EXEC_EVENT.data_crc_fault,
			EXEC_EVENT.wrong_cylinder,
			EXEC_EVENT.scan_cmd && EXEC_EVENT.scan_equal,
			EXEC_EVENT.scan_cmd && EXEC_EVENT.scan_unmet,
			EXEC_EVENT.bad_cylinder,
			EXEC_EVENT.read_or_scan && EXEC_EVENT.addr_mark_absent};
	end

	// result stack: one byte per port read, zero then one then two
	assign port_rd = rd_fire && S_AXI_ARADDR == ADDR_PORT;
	always_comb
	begin
		case (ptr_q)
			PTR_ZERO: port_byte = st0_q;
			PTR_ONE:  port_byte = st1_q;
			PTR_TWO:  port_byte = st2_q;
			default:  port_byte = BYTE_ZERO;
		endcase
		if (!result_q)
			port_byte = BYTE_ZERO;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			st0_q    <= BYTE_ZERO;
			st1_q    <= BYTE_ZERO;
			st2_q    <= BYTE_ZERO;
			result_q <= 1'b0;
			ptr_q    <= PTR_ZERO;
		end
		else if (CE)
		begin
			if (busy_q && (EXEC_EVENT.done || EXEC_EVENT.invalid))
			begin
				st0_q    <= st0_d;
				st1_q    <= st1_d;
				st2_q    <= st2_d;
				result_q <= 1'b1;
				ptr_q    <= PTR_ZERO;
			end
			else if (port_rd && result_q)
			begin
				// host walks the stack in order; last read frees the port
				case (ptr_q)
					PTR_ZERO: ptr_q <= PTR_ONE;
					PTR_ONE:  ptr_q <= PTR_TWO;
					PTR_TWO:
					begin
						ptr_q    <= PTR_ZERO;
						result_q <= 1'b0;
					end
					default:  ptr_q <= PTR_ZERO;
				endcase
			end
		end
	end

	// read channel: answer one cycle after the address is taken
	assign S_AXI_ARREADY = !rvalid_q;
	assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RDATA   = rdata_q;
	assign S_AXI_RRESP   = rresp_q;

	always_comb
	begin
		rd_word = WORD_ZERO;
		rd_ok   = 1'b1;
		case (S_AXI_ARADDR)
			ADDR_PORT:     rd_word[7:0] = port_byte;
			ADDR_CONTROL:  rd_word[2:0] = control_q;
			ADDR_STATE:
			begin
				rd_word[STATE_PTR_LO +: 2] = ptr_q;
				rd_word[STATE_ENABLED]     = enabled_q;
				rd_word[STATE_BUSY]        = busy_q;
				rd_word[STATE_RESULT]      = result_q;
			end
			ADDR_CMD_LAST: rd_word[7:0] = cmd_last_q;
			default:       rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= WORD_ZERO;
			rresp_q  <= AXI_OKAY;
		end
		else if (CE)
		begin
			if (rd_fire)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_RREADY)
				rvalid_q <= 1'b0;
		end
	end

endmodule // floppy_result_status

// >>> floppy_result_status_monitor.sv
/*
 * Checker for the result-status block bus behaviour.
 * Assumes binding onto floppy_result_status with CE dropped only while
 * the bus is idle and no command strobe stands.
 */
module floppy_result_status_monitor
	import fdc_result_pkg::*;
(
	// clock, reset
	input wire logic        CLK,
	input wire logic        RESET_N,
	// register bus
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [7:0]  S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0]  S_AXI_RRESP,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	// core side
	input wire logic        CMD_STROBE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	sequence ar_taken;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	sequence port_read;
		ar_taken ##0 S_AXI_ARADDR == ADDR_PORT;
	endsequence

	wire mapped = S_AXI_ARADDR inside {ADDR_PORT, ADDR_CONTROL, ADDR_STATE, ADDR_CMD_LAST};

	a_read_answer: assert property (ar_taken |=> S_AXI_RVALID)
		else $error("read not answered");
	a_bad_addr: assert property (ar_taken ##0 !mapped |=> S_AXI_RRESP == AXI_SLVERR)
		else $error("unmapped read not refused");
	a_port_okay: assert property (port_read |=> S_AXI_RRESP == AXI_OKAY)
		else $error("port read refused");
	a_upper_zero: assert property (port_read |=> S_AXI_RDATA[31:8] == 24'h0)
		else $error("port read wider than a byte");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read accepted while busy");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write accepted while answering");
	a_strobe_pulse: assert property (CMD_STROBE |=> !CMD_STROBE)
		else $error("command strobe too long");
endmodule // floppy_result_status_monitor

bind floppy_result_status floppy_result_status_monitor i_floppy_result_status_monitor (
	.CLK, .RESET_N, .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
	.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .CMD_STROBE);

// >>> floppy_core_model.sv
/*
 * Model of controller core and drive: event pulses and pin levels.
 * Assumes the bench asks for an event one cycle ahead on the same clock.
 */
module floppy_core_model
	import fdc_result_pkg::*;
(
	// clock
	input wire logic  CLK,
	// bench requests
	input wire logic        fire,
	input wire exec_event_s ev_in,
	input wire drive_pins_s pins_in,
	// to the block
	output exec_event_s exec_event,
	output drive_pins_s drive_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// events last as many cycles as fire is held, all zero between them
	always_ff @(posedge CLK)
		exec_event <= fire ? ev_in : '0;
	always_ff @(posedge CLK)
		drive_pins <= pins_in;
endmodule // floppy_core_model

// >>> floppy_result_status_tb_top.sv
/*
 * Self-checking bench for the result-status block.
 * Assumes the core model stands in for controller core and drive pins.
 */
module floppy_result_status_tb_top
	import fdc_result_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, fire = 1'b0, ce = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid, cmd_strobe;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [7:0]  cmd_byte, cmd;
	logic [23:0] e;
	logic [3:0]  ctl;
	exec_event_s ev = '0, nv, exev;
	drive_pins_s pins = 4'h2, np, drv;
	int          error_cnt = 0, samples_checked = 0, seed = 25, cyc = 0, strobes = 0;

	initial forever #5 clk = ~clk;

	floppy_core_model i_floppy_core_model (.CLK(clk), .fire(fire), .ev_in(ev),
		.pins_in(pins), .exec_event(exev), .drive_pins(drv));
	floppy_result_status i_floppy_result_status (.CLK(clk), .RESET_N(reset_n),
		.CE(ce), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.EXEC_EVENT(exev), .CMD_STROBE(cmd_strobe), .CMD_BYTE(cmd_byte),
		.DRIVE_PINS(drv));

	task automatic print_verdict();
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cmd_strobe)
			strobes++;
		if (cyc > 20000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, ra, wa;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		// readies come from held state only, so read them settled mid-cycle
		while (!(ta && tw))
		begin
			@(negedge clk);
			ra = awready && !ta;
			wa = wready && !tw;
			@(posedge clk);
			if (ra)
				awvalid <= 1'b0;
			if (wa)
				wvalid <= 1'b0;
			ta |= ra;
			tw |= wa;
		end
		bready <= 1'b1;
		do @(negedge clk); while (!bvalid);
		chk(bresp, AXI_OKAY);
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(negedge clk); while (!rvalid);
		v = rdata;
		rr = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	// one event pulse from the core model, seen one cycle later
	task automatic pulse(input exec_event_s v);
		ev <= v;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	// three stacked bytes in order, then an empty port
	task automatic check_result(input logic [23:0] e);
		logic [31:0] v;
		logic [1:0]  rr;
		for (int k = 0; k < 4; k++)
		begin
			rd(ADDR_PORT, v, rr);
			chk(v, k < 3 ? 32'(e[k*8 +: 8]) : 32'h0);
		end
	endtask

	function automatic logic [23:0] expect_st(exec_event_s v, drive_pins_s p, logic [2:0] c);
		logic [7:0] s0, s1, s2;
		s1 = {v.past_last_sector, 1'b0, v.id_crc_fault | v.data_crc_fault, v.host_late, 1'b0,
			v.sector_missing, v.write_cmd & p.write_protect, v.addr_mark_absent};
		s2 = {1'b0, v.read_or_scan & v.control_mark, v.data_crc_fault, v.wrong_cylinder,
			v.scan_cmd & v.scan_equal, v.scan_cmd & v.scan_unmet, v.bad_cylinder,
			v.read_or_scan & v.addr_mark_absent};
		s0 = {v.invalid ? IC_INVALID : (|{s1, s2, p.fault, v.seek_cmd & ~v.seek_ok}) ?
			IC_ABNORMAL : IC_NORMAL, v.seek_cmd & v.seek_ok, p.fault, ~p.ready, c};
		return {s2, s1, s0};
	endfunction

	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		rd(ADDR_STATE, d, r);
		chk(d, 32'h0);
		wr(ADDR_PORT, 32'h46);
		wr(ADDR_PORT, 32'(CMD_CONFIGURE));
		rd(ADDR_STATE, d, r);
		chk({d[STATE_ENABLED], 8'(strobes)}, 9'h100);
		rd(8'h0c, d, r);
		chk(32'(r), 32'(AXI_SLVERR));
		chk(d, WORD_ZERO);
		rd(ADDR_PORT, d, r);
		chk(d, 32'h0);
		// corner: drive ready drops while the command runs
		wr(ADDR_CONTROL, 32'h5);
		wr(ADDR_PORT, 32'h46);
		chk(32'(cmd_byte), 32'h46);
		pins <= 4'h0;
		repeat (5) @(posedge clk);
		nv = '0;
		nv.done = 1'b1;
		pulse(nv);
		repeat (2) @(posedge clk);
		check_result({16'h0, IC_RDY_CHG, 3'b001, 3'b101});
		// corner: 80 steps with track zero never seen
		pins <= 4'h2;
		repeat (4) @(posedge clk);
		wr(ADDR_PORT, 32'h46);
		nv = '0;
		nv.step = 1'b1;
		ev <= nv;
		fire <= 1'b1;
		repeat (80) @(posedge clk);
		nv = '0;
		nv.done = 1'b1;
		nv.host_late = 1'b1;
		pulse(nv);
		repeat (2) @(posedge clk);
		check_result({8'h00, 8'h10, IC_ABNORMAL, 3'b010, 3'b101});
		// corner: an end pulse while the clock enable is low is not seen
		wr(ADDR_PORT, 32'h46);
		ce <= 1'b0;
		nv = '0;
		nv.done = 1'b1;
		pulse(nv);
		@(posedge clk);
		ce <= 1'b1;
		rd(ADDR_STATE, d, r);
		chk(d, 32'h0000_000c);
		pulse(nv);
		repeat (2) @(posedge clk);
		check_result({16'h0, IC_NORMAL, 3'b000, 3'b101});
		for (int i = 0; i < 40; i++)
		begin
			ctl = 4'($random(seed));
			np = 4'($random(seed));
			nv = 19'($random(seed));
			nv.done = 1'b1;
			nv.invalid = 1'b0;
			nv.step = 1'b0;
			// invalid ends carry no other event and no fault, except host_late added below when ready is low
			if (i % 5 == 0)
			begin
				nv = '0;
				nv.invalid = 1'b1;
				np.fault = 1'b0;
			end
			// not-ready alone leaves the code open, so pair it with host_late
			if (!np.ready)
				nv.host_late = 1'b1;
			cmd = 8'($random(seed));
			if (cmd == CMD_CONFIGURE)
				cmd = 8'h46;
			pins <= np;
			wr(ADDR_CONTROL, 32'(ctl));
			repeat (3) @(posedge clk);
			wr(ADDR_PORT, 32'(cmd));
			chk(32'(cmd_byte), 32'(cmd));
			@(posedge clk);
			pulse(nv);
			e = expect_st(nv, np, ctl[2:0]);
			repeat (2) @(posedge clk);
			check_result(e);
		end
		print_verdict();
	end
endmodule // floppy_result_status_tb_top
